/* rtl/draw_fifo.v */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module draw_fifo #(
  parameter W = 16,
  parameter D = 32
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire in_valid_i,
  input wire [W-1:0] in_data_i,
  output wire in_ready_o,
  output wire out_valid_o,
  output wire [W-1:0] out_data_o,
  input wire out_ready_i,
  output wire [$clog2(D):0] count_o
);
  localparam AW = $clog2(D);
  localparam [AW:0] FULL = D;
  localparam [AW:0] ONE = 1;
  reg [W-1:0] mem_ff [0:D-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] cnt_ff;
  reg rdy_ff;
  reg val_ff;
  wire push = in_valid_i & rdy_ff;
  wire pop = out_ready_i & val_ff;
  wire [AW:0] nxt_cnt = push & !pop ? cnt_ff + ONE :
                        pop & !push ? cnt_ff - ONE : cnt_ff;
  assign in_ready_o = rdy_ff;
  assign out_valid_o = val_ff;
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign count_o = cnt_ff;
  // storage write, no reset needed
  always @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end
  // pointers and registered full/empty
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      rdy_ff <= 1'b0;
      val_ff <= 1'b0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      cnt_ff <= nxt_cnt;
      rdy_ff <= (nxt_cnt != FULL);
      val_ff <= (nxt_cnt != {(AW+1){1'b0}});
    end
  end
endmodule // draw_fifo
`default_nettype wire

/* rtl/draw_mixer.v */
// bitmap mix unit: combines source color with existing pixel
`timescale 1ns/1ps
`default_nettype none
`include "gui_draw_map.vh"
module draw_mixer (
  input wire [4:0] mix_i,
  input wire [7:0] src_i,
  input wire [7:0] dst_i,
  output reg [7:0] res_o
);
  // one function per mix code
  always @* begin
    case (mix_i)
      `MX_NOT_DST: res_o = ~dst_i;
      `MX_ZERO: res_o = 8'h00;
      `MX_ONE: res_o = 8'hff;
      `MX_DST: res_o = dst_i;
      `MX_NOT_SRC: res_o = ~src_i;
      `MX_XOR: res_o = src_i ^ dst_i; // R2
      `MX_XNOR: res_o = ~(src_i ^ dst_i);
      `MX_NEW: res_o = src_i; // R19
      `MX_NAND: res_o = ~(src_i & dst_i);
      `MX_DST_OR_NSRC: res_o = dst_i | ~src_i;
      `MX_SRC_OR_NDST: res_o = src_i | ~dst_i;
      `MX_OR: res_o = src_i | dst_i;
      `MX_AND: res_o = src_i & dst_i;
      `MX_SRC_AND_NDST: res_o = src_i & ~dst_i;
      `MX_DST_AND_NSRC: res_o = dst_i & ~src_i;
      `MX_NOR: res_o = ~(src_i | dst_i);
      default: res_o = src_i;
    endcase
  end
endmodule // draw_mixer
`default_nettype wire

/* rtl/gui_draw_command_engine.v */
// drawing engine front end: host registers, command walk, pixel writes
`timescale 1ns/1ps
`default_nettype none
`include "gui_draw_map.vh"
// How it works
// [R1] texture bit 1 uses foreground color/mix, bit 0 background.
// [R2] background mix code 00101 means source xor bitmap.
// [R3] host texture words come via pixel port, one bit per pixel.
// [R4] without host wait, comparison word texture repeats along line.
// [R5] command top bits give type; bit4 draw, bit1 multi, bit0 write.
// [R6] bit 9 selects 16-bit host words; bit 8 waits host data.
// [R7] bit 12 swaps byte order of host image words.
// [R8] rectangles are X major: walk rows in X, step rows in Y.
// [R9] bit 5 positive X, bit 7 positive Y set start corner.
// [R10] host loads error term and step constants for lines.
// [R11] odd row at one byte per pixel: dummy byte discarded.
// [R12] 4-bit pixels: upper nibble first, lower nibble next.
// [R13] 4-bit pixels: rows padded to four, dummies dropped.
// [R14] 8-bit transfers: one pixel per byte, two when 4-bit.
// [R15] foreground mix source field picks host data or color.
// [R16] control A080 lets host mask pick fg/bg mix; A000 fg.
// [R17] host waits for enough free command fifo entries.
// [R18] status bit i set means entries 1..i+1 occupied.
// [R19] mix code 00111 replaces bitmap with source.
// [R20] bit 7 set steps Y positive, clear negative.
module gui_draw_command_engine (
  input wire clk_i,
  input wire rst_b_i,
  input wire io_wr_i,
  input wire io_rd_i,
  input wire [15:0] io_addr_i,
  input wire [15:0] io_wdata_i,
  output reg [15:0] io_rdata_o,
  output wire cmd_ready_o,
  output wire pix_ready_o,
  input wire bpp4_i,
  output reg vm_req_o,
  output reg vm_we_o,
  output reg [11:0] vm_x_o,
  output reg [11:0] vm_y_o,
  output reg [7:0] vm_wdata_o,
  input wire vm_ack_i,
  input wire [7:0] vm_rdata_i
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_PIX = 4'h2;
  localparam [3:0] S_RD = 4'h4;
  localparam [3:0] S_WR = 4'h8;
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_meta_ff;
  reg rst_n_ff;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end
  // ----------------------------------------------------------------
  // fifos: register writes and host pixel data
  // ----------------------------------------------------------------
  wire is_pix = (io_addr_i == `A_PIXEL);
  wire cmd_valid;
  wire [31:0] cmd_entry;
  wire cmd_pop;
  wire [3:0] cmd_cnt;
  wire pix_valid;
  wire [15:0] pix_data;
  wire pix_pop;
  draw_fifo #(.W(32), .D(`CMD_DEPTH)) u_cmd_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_ff),
    .in_valid_i(io_wr_i & !is_pix),
    .in_data_i({io_addr_i, io_wdata_i}),
    .in_ready_o(cmd_ready_o),
    .out_valid_o(cmd_valid),
    .out_data_o(cmd_entry),
    .out_ready_i(cmd_pop),
    .count_o(cmd_cnt)
  );
  draw_fifo #(.W(16), .D(`PIX_DEPTH)) u_pix_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_ff),
    .in_valid_i(io_wr_i & is_pix),
    .in_data_i(io_wdata_i),
    .in_ready_o(pix_ready_o),
    .out_valid_o(pix_valid),
    .out_data_o(pix_data),
    .out_ready_i(pix_pop),
    .count_o()
  );
  wire [15:0] e_addr = cmd_entry[31:16];
  wire [15:0] e_data = cmd_entry[15:0];
  // ----------------------------------------------------------------
  // engine registers and walk state
  // ----------------------------------------------------------------
  reg [3:0] state_ff;
  reg [15:0] fg_mix_ff;
  reg [15:0] bg_mix_ff;
  reg [7:0] fg_col_ff;
  reg [7:0] bg_col_ff;
  reg mask_mode_ff;
  reg [11:0] x_ff;
  reg [11:0] y_ff;
  reg [11:0] maj_ff;
  reg [11:0] min_ff;
  reg [15:0] axial_ff;
  reg [15:0] diag_ff;
  reg [15:0] err_ff;
  reg [15:0] cmp_ff;
  reg [15:0] cmd_ff;
  reg [11:0] cnt_ff;
  reg [11:0] rows_ff;
  reg [11:0] rowx_ff;
  reg [3:0] slot_ff;
  reg [4:0] mix_ff;
  reg [7:0] src_ff;
  reg [7:0] fifo_st_ff;
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire is_line = (cmd_ff[`C_TYPE] == `T_LINE); // R5
  wire is_rect = (cmd_ff[`C_TYPE] == `T_RECT); // R5
  wire bus16 = cmd_ff[`C_BUS16]; // R6
  wire wait_host = cmd_ff[`C_WAIT]; // R6
  wire swap = cmd_ff[`C_SWAP]; // R7
  wire [11:0] dx = cmd_ff[`C_XPOS] ? `STEP_POS : `STEP_NEG; // R9
  wire [11:0] dy = cmd_ff[`C_YPOS] ? `STEP_POS : `STEP_NEG; // R20
  wire new_type = (e_data[`C_TYPE] == `T_LINE) |
                  (e_data[`C_TYPE] == `T_RECT);
  wire starts = new_type & e_data[`C_DRAW] & e_data[`C_WRITE]; // R5
  // ----------------------------------------------------------------
  // texture bit and host pixel extraction
  // ----------------------------------------------------------------
  // texture from host words or the repeated comparison word
  wire [15:0] tex_word = wait_host ? pix_data : cmp_ff; // R3 R4
  wire tex_bit = tex_word[`TEX_TOP - slot_ff];
  // last slot of a host word before it is popped
  wire [3:0] slot_lim = mask_mode_ff ? `TEX_TOP :
                        bpp4_i ? (bus16 ? `SLOT_4 : `SLOT_2) : // R13 R14
                        (bus16 ? `SLOT_2 : `SLOT_1); // R11 R14
  wire [7:0] byte_1st = swap ? pix_data[`LO_BYTE] : pix_data[`HI_BYTE]; // R7
  wire [7:0] byte_2nd = swap ? pix_data[`HI_BYTE] : pix_data[`LO_BYTE]; // R7
  wire byte_pick = bpp4_i ? slot_ff[1] : slot_ff[0];
  wire [7:0] byte_sel = !bus16 ? pix_data[`LO_BYTE] :
                        (byte_pick ? byte_2nd : byte_1st);
  // upper nibble is the earlier pixel
  wire [3:0] nib = slot_ff[0] ? byte_sel[`LO_NIB] : byte_sel[`HI_NIB]; // R12
  wire [7:0] host_px = bpp4_i ? {4'h0, nib} : byte_sel;
  // ----------------------------------------------------------------
  // per pixel color and mix choice
  // ----------------------------------------------------------------
  wire use_fg = !mask_mode_ff | tex_bit; // R1 R16
  wire [15:0] mix_word = use_fg ? fg_mix_ff : bg_mix_ff; // R1
  reg [7:0] src_sel;
  always @* begin
    case (mix_word[`MIX_SRC])
      `SRC_BG: src_sel = bg_col_ff;
      `SRC_FG: src_sel = fg_col_ff; // R15
      `SRC_HOST: src_sel = host_px; // R15
      default: src_sel = fg_col_ff;
    endcase
  end
  wire [7:0] mix_res;
  draw_mixer u_mixer (
    .mix_i(mix_ff),
    .src_i(src_ff),
    .dst_i(vm_rdata_i),
    .res_o(mix_res)
  );
  // ----------------------------------------------------------------
  // walk control
  // ----------------------------------------------------------------
  wire host_ok = !wait_host | pix_valid; // R6
  wire wr_done = (state_ff == S_WR) & vm_ack_i;
  wire last = (cnt_ff == 12'h000);
  wire word_end = (slot_ff == slot_lim) | last;
  wire err_pos = !err_ff[`ERR_SIGN];
  assign cmd_pop = (state_ff == S_IDLE) & cmd_valid;
  // row-end pop drops padding bytes or pixels
  assign pix_pop = wr_done & wait_host & word_end; // R3 R11 R13
  // ----------------------------------------------------------------
  // register writes and pixel walk
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= S_IDLE;
      fg_mix_ff <= 16'h0000;
      bg_mix_ff <= 16'h0000;
      fg_col_ff <= 8'h00;
      bg_col_ff <= 8'h00;
      mask_mode_ff <= 1'b0;
      x_ff <= 12'h000;
      y_ff <= 12'h000;
      maj_ff <= 12'h000;
      min_ff <= 12'h000;
      axial_ff <= 16'h0000;
      diag_ff <= 16'h0000;
      err_ff <= 16'h0000;
      cmp_ff <= 16'h0000;
      cmd_ff <= 16'h0000;
      cnt_ff <= 12'h000;
      rows_ff <= 12'h000;
      rowx_ff <= 12'h000;
      slot_ff <= 4'h0;
      mix_ff <= 5'h00;
      src_ff <= 8'h00;
      vm_req_o <= 1'b0;
      vm_we_o <= 1'b0;
      vm_x_o <= 12'h000;
      vm_y_o <= 12'h000;
      vm_wdata_o <= 8'h00;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (cmd_valid) begin
            case (e_addr)
              `A_FG_MIX: fg_mix_ff <= e_data;
              `A_BG_MIX: bg_mix_ff <= e_data;
              `A_FG_COLOR: fg_col_ff <= e_data[`LO_BYTE];
              `A_BG_COLOR: bg_col_ff <= e_data[`LO_BYTE];
              `A_START_X: x_ff <= e_data[`MULTI_VAL];
              `A_START_Y: y_ff <= e_data[`MULTI_VAL];
              `A_MAJ_CNT: maj_ff <= e_data[`MULTI_VAL];
              `A_AXIAL: axial_ff <= e_data; // R10
              `A_DIAG: diag_ff <= e_data;
              `A_ERR: err_ff <= e_data; // R10
              `A_CMP: cmp_ff <= e_data; // R4
              `A_MULTI: begin
                if (e_data[`MULTI_IDX] == `IDX_MIN) begin
                  min_ff <= e_data[`MULTI_VAL];
                end else if (e_data[`MULTI_IDX] == `IDX_CTRL) begin
                  mask_mode_ff <= e_data[`CTRL_MASK_BIT]; // R16
                end
              end
              `A_CMD: begin
                cmd_ff <= e_data;
                cnt_ff <= maj_ff;
                rows_ff <= min_ff;
                rowx_ff <= x_ff;
                slot_ff <= 4'h0;
                if (starts) state_ff <= S_PIX; // R5
              end
              default: ;
            endcase
          end
        end
        S_PIX: begin
          // stall until host data is present
          if (host_ok) begin // R6
            mix_ff <= mix_word[`MIX_CODE];
            src_ff <= src_sel;
            vm_req_o <= 1'b1;
            vm_we_o <= 1'b0;
            vm_x_o <= x_ff;
            vm_y_o <= y_ff;
            state_ff <= S_RD;
          end
        end
        S_RD: begin
          // existing pixel back: issue the mixed write
          if (vm_ack_i) begin
            vm_we_o <= 1'b1;
            vm_wdata_o <= mix_res; // R2 R19
            state_ff <= S_WR;
          end
        end
        S_WR: begin
          if (vm_ack_i) begin
            vm_req_o <= 1'b0;
            vm_we_o <= 1'b0;
            slot_ff <= word_end ? 4'h0 : slot_ff + 4'h1; // R3 R4
            cnt_ff <= last ? maj_ff : cnt_ff - 12'h001;
            if (is_line) begin
              // axial / diagonal step on the sign of the error term
              if (cmd_ff[`C_XMAJ]) begin
                x_ff <= x_ff + dx;
                if (err_pos) y_ff <= y_ff + dy; // R20
              end else begin
                y_ff <= y_ff + dy; // R20
                if (err_pos) x_ff <= x_ff + dx;
              end
              err_ff <= err_ff + (err_pos ? diag_ff : axial_ff); // R10
              state_ff <= last ? S_IDLE : S_PIX;
            end else if (is_rect) begin
              // rows run along X, then step once in Y
              if (!last) begin
                x_ff <= x_ff + dx; // R8 R9
                state_ff <= S_PIX;
              end else if (rows_ff == 12'h000) begin
                state_ff <= S_IDLE;
              end else begin
                rows_ff <= rows_ff - 12'h001;
                x_ff <= rowx_ff; // R8
                y_ff <= y_ff + dy; // R8 R9
                state_ff <= S_PIX;
              end
            end else begin
              state_ff <= S_IDLE;
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // fifo occupancy status and read port
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `CMD_DEPTH; i = i + 1) begin : g_st
      localparam [3:0] LVL = i;
      // thermometer of occupied entries
      always @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          fifo_st_ff[i] <= 1'b0;
        end else begin
          fifo_st_ff[i] <= (cmd_cnt > LVL); // R18 R17
        end
      end
    end
  endgenerate
  wire busy = (state_ff != S_IDLE) | cmd_valid | fifo_st_ff[0];
  // status read; other addresses answer zero
  always @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      io_rdata_o <= 16'h0000;
    end else if (io_rd_i & (io_addr_i == `A_CMD)) begin
      io_rdata_o <= 16'h0000;
      io_rdata_o[`LO_BYTE] <= fifo_st_ff; // R18
      io_rdata_o[`ST_BUSY] <= busy;
    end else begin
      io_rdata_o <= 16'h0000;
    end
  end
endmodule // gui_draw_command_engine
`default_nettype wire

/* rtl/gui_draw_map.vh */
// register addresses, command fields and mix codes of the drawing engine
`ifndef GUI_DRAW_MAP_VH
`define GUI_DRAW_MAP_VH
// ----------------------------------------------------------------
// host i/o port addresses
// ----------------------------------------------------------------
`define A_FG_MIX 16'hbae8
`define A_BG_MIX 16'hb6e8
`define A_FG_COLOR 16'ha6e8
`define A_BG_COLOR 16'ha2e8
`define A_MULTI 16'hbee8
`define A_START_X 16'h86e8
`define A_START_Y 16'h82e8
`define A_MAJ_CNT 16'h96e8
`define A_AXIAL 16'h8ae8
`define A_DIAG 16'h8ee8
`define A_ERR 16'h92e8
`define A_CMD 16'h9ae8
`define A_PIXEL 16'he2e8
`define A_CMP 16'hb2e8
// ----------------------------------------------------------------
// multipurpose control index field
// ----------------------------------------------------------------
`define MULTI_IDX 15:12
`define MULTI_VAL 11:0
`define IDX_MIN 4'h0
`define IDX_CTRL 4'ha
`define CTRL_MASK_BIT 7
// ----------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------
`define C_TYPE 15:13
`define T_LINE 3'h1
`define T_RECT 3'h2
`define C_SWAP 12
`define C_BUS16 9
`define C_WAIT 8
`define C_YPOS 7
`define C_XMAJ 6
`define C_XPOS 5
`define C_DRAW 4
`define C_MULTI 1
`define C_WRITE 0
// ----------------------------------------------------------------
// mix register fields and codes
// ----------------------------------------------------------------
`define MIX_CODE 4:0
`define MIX_SRC 6:5
`define SRC_BG 2'h0
`define SRC_FG 2'h1
`define SRC_HOST 2'h2
`define MX_NOT_DST 5'h00
`define MX_ZERO 5'h01
`define MX_ONE 5'h02
`define MX_DST 5'h03
`define MX_NOT_SRC 5'h04
`define MX_XOR 5'h05
`define MX_XNOR 5'h06
`define MX_NEW 5'h07
`define MX_NAND 5'h08
`define MX_DST_OR_NSRC 5'h09
`define MX_SRC_OR_NDST 5'h0a
`define MX_OR 5'h0b
`define MX_AND 5'h0c
`define MX_SRC_AND_NDST 5'h0d
`define MX_DST_AND_NSRC 5'h0e
`define MX_NOR 5'h0f
// ----------------------------------------------------------------
// data packing, stepping and status
// ----------------------------------------------------------------
`define LO_BYTE 7:0
`define HI_BYTE 15:8
`define HI_NIB 7:4
`define LO_NIB 3:0
`define TEX_TOP 4'hf
`define SLOT_1 4'h0
`define SLOT_2 4'h1
`define SLOT_4 4'h3
`define STEP_POS 12'h001
`define STEP_NEG 12'hfff
`define ERR_SIGN 15
`define ST_BUSY 9
`define CMD_DEPTH 8
`define PIX_DEPTH 32
`endif

/* verification/draw_engine_monitor.sv */
// port timing checker of the drawing engine
`timescale 1ns/1ps
`default_nettype none
`include "gui_draw_map.vh"
module draw_engine_monitor (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [15:0] io_rdata_o,
  input wire logic vm_req_o,
  input wire logic vm_we_o,
  input wire logic [11:0] vm_x_o,
  input wire logic [11:0] vm_y_o,
  input wire logic [7:0] vm_wdata_o,
  input wire logic vm_ack_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // --------------------
  // memory request framing
  // --------------------
  property p_hold;
    vm_req_o && !vm_ack_i |=> vm_req_o && $stable({vm_we_o, vm_x_o, vm_y_o});
  endproperty
  a_hold: assert property (p_hold)
    else $error("request moved before ack");
  property p_wdat;
    vm_req_o && vm_we_o && !vm_ack_i |=> $stable(vm_wdata_o);
  endproperty
  a_wdat: assert property (p_wdat)
    else $error("write data moved before ack");
  property p_rmw;
    vm_req_o && !vm_we_o && vm_ack_i
      |=> vm_req_o && vm_we_o && $stable({vm_x_o, vm_y_o});
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("read not followed by write of same pixel");
  property p_gap;
    vm_req_o && vm_we_o && vm_ack_i |=> !vm_req_o;
  endproperty
  a_gap: assert property (p_gap)
    else $error("request not dropped after write");
  property p_first;
    $rose(vm_req_o) |-> !vm_we_o;
  endproperty
  a_first: assert property (p_first)
    else $error("pixel written without reading it");
  // --------------------
  // status read port
  // --------------------
  property p_idle;
    !io_rd_i |=> io_rdata_o == 16'h0000;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data without read");
  property p_unmap;
    io_rd_i && io_addr_i != `A_CMD |=> io_rdata_o == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_thermo;
    io_rd_i && io_addr_i == `A_CMD
      |=> (io_rdata_o[7:0] & (io_rdata_o[7:0] + 8'h01)) == 8'h00;
  endproperty
  a_thermo: assert property (p_thermo)
    else $error("fifo status not contiguous");
  property p_busy;
    io_rd_i && io_addr_i == `A_CMD
      |=> !(io_rdata_o[0] && !io_rdata_o[`ST_BUSY]);
  endproperty
  a_busy: assert property (p_busy)
    else $error("entries pending but not busy");
endmodule // draw_engine_monitor
bind gui_draw_command_engine draw_engine_monitor u_mon (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .io_rd_i(io_rd_i),
  .io_addr_i(io_addr_i), .io_rdata_o(io_rdata_o), .vm_req_o(vm_req_o),
  .vm_we_o(vm_we_o), .vm_x_o(vm_x_o), .vm_y_o(vm_y_o),
  .vm_wdata_o(vm_wdata_o), .vm_ack_i(vm_ack_i));
`default_nettype wire

/* verification/tb_top.sv */
// self-checking drawing engine bench
`timescale 1ns/1ps
`default_nettype none
`include "gui_draw_map.vh"
module tb_top;
  logic clk_i, rst_b_i, io_wr_i, io_rd_i, bpp4_i, vm_ack_i;
  logic cmd_ready_o, pix_ready_o, vm_req_o, vm_we_o;
  logic [15:0] io_addr_i, io_wdata_i, io_rdata_o;
  logic [11:0] vm_x_o, vm_y_o;
  logic [7:0] vm_wdata_o, vm_rdata_i;
  logic [7:0] exp_mem [0:255];
  logic [39:0] exp_q [$];
  logic [39:0] e;
  int n_errors, num_checks;
  gui_draw_command_engine u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .cmd_ready_o(cmd_ready_o), .pix_ready_o(pix_ready_o), .bpp4_i(bpp4_i),
    .vm_req_o(vm_req_o), .vm_we_o(vm_we_o), .vm_x_o(vm_x_o),
    .vm_y_o(vm_y_o), .vm_wdata_o(vm_wdata_o), .vm_ack_i(vm_ack_i),
    .vm_rdata_i(vm_rdata_i));
  vmem_model u_mem (.clk_i(clk_i), .req_i(vm_req_o), .we_i(vm_we_o),
    .x_i(vm_x_o), .y_i(vm_y_o), .wdata_i(vm_wdata_o), .ack_o(vm_ack_i),
    .rdata_o(vm_rdata_i));
  // --------------------
  // clock, checks, verdict
  // --------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic timeout();
    n_errors++;
    $display("mismatch wait expected done seen timeout");
    conclude();
  endtask
  task automatic chk_reg(string what, logic [15:0] ex, logic [15:0] got);
    num_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, ex, got);
    end
  endtask
  task automatic chk_pix(logic [31:0] ex, logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("mismatch pixel expected %h seen %h", ex, got);
    end
  endtask
  // each acked pixel write vs the model queue
  always @(posedge clk_i) begin
    if (vm_req_o === 1'b1 && vm_we_o === 1'b1 && vm_ack_i === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 40'hff_ffff_ffff;
      chk_pix(e[31:0], {vm_x_o, vm_y_o, vm_wdata_o & e[39:32]});
    end
  end
  // --------------------
  // behavioural pixel model
  // --------------------
  task automatic push(int x, int y, logic [4:0] c, logic [7:0] s,
                      logic [7:0] m);
    logic [7:0] i;
    logic [7:0] v;
    i = {y[3:0], x[3:0]};
    v = (c == 5'h05) ? s ^ exp_mem[i] : s;
    exp_mem[i] = v;
    exp_q.push_back({m, x[11:0], y[11:0], v & m});
  endtask
  // --------------------
  // host side access
  // --------------------
  task automatic wr(logic [15:0] a, logic [15:0] d);
    int k;
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    for (k = 0; k < 400; k++) begin
      if (((a == `A_PIXEL) ? pix_ready_o : cmd_ready_o) === 1'b1)
        break;
      @(posedge clk_i) #1;
    end
    if (k == 400)
      timeout();
    @(posedge clk_i) #1;
  endtask
  task automatic rd(logic [15:0] a, output logic [15:0] v);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(posedge clk_i) #1;
    v = io_rdata_o;
    io_rd_i = 1'b0;
    @(posedge clk_i) #1;
  endtask
  task automatic poll(int bitn, string name);
    logic [15:0] s;
    int k;
    io_wr_i = 1'b0;
    for (k = 0; k < 3000; k++) begin
      rd(`A_CMD, s);
      if (s[bitn] === 1'b0 && (name == "" || exp_q.size() == 0))
        break;
    end
    if (k == 3000)
      timeout();
    if (name != "")
      $display("test %s done, %0d mismatches", name, n_errors);
  endtask
  task automatic rect(logic [15:0] cmd, int w, int h);
    poll(3, "");
    wr(`A_START_X, 16'd8);
    wr(`A_START_Y, 16'd8);
    wr(`A_MAJ_CNT, 16'(w - 1));
    wr(`A_MULTI, {`IDX_MIN, 12'(h - 1)});
    wr(`A_CMD, cmd);
  endtask
  task automatic line(int m, logic [7:0] c1, logic [7:0] c2);
    logic [15:0] p [2];
    int xs, b;
    p[0] = 16'($urandom());
    p[1] = (m == 2) ? 16'($urandom()) : p[0];
    xs = (m == 1) ? 15 : 0;
    for (int i = 0; i < 18; i++) begin
      b = p[i / 16][15 - i % 16];
      push((m == 1) ? xs - i : xs + i, 3, b ? 5'h07 : 5'h05,
           b ? c1 : c2, 8'hff);
    end
    poll(0, "");
    wr(`A_START_X, 16'(xs));
    wr(`A_START_Y, 16'h0003);
    wr(`A_MAJ_CNT, 16'd17);
    wr(`A_DIAG, 16'hffde);
    wr(`A_AXIAL, 16'h0000);
    wr(`A_ERR, (m == 1) ? 16'hffee : 16'hffef);
    wr(`A_CMP, p[0]);
    wr(`A_CMD, (m == 2) ? 16'h23f3 : (m == 1) ? 16'h20d3 : 16'h20f3);
    for (int i = 0; i < 2 && m == 2; i++)
      wr(`A_PIXEL, p[i]);
    poll(`ST_BUSY, "textured line");
  endtask
  task automatic image(logic bus, logic swp, logic b4, int w);
    logic [15:0] q [$];
    logic [7:0] by [$];
    logic [15:0] d;
    int n;
    bpp4_i = b4;
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < (bus || b4 ? (w + 1) / 2 : w); k++) begin
        d = 16'($urandom());
        q.push_back(d);
        by.push_back((bus && !swp) ? d[15:8] : d[7:0]);
        if (bus)
          by.push_back(swp ? d[15:8] : d[7:0]);
        if (b4 && bus && k == (w + 3) / 4 - 1)
          break;
      end
      n = 0;
      while (by.size() > 0) begin
        d[7:0] = by.pop_front();
        for (int j = 0; j <= int'(b4); j++) begin
          if (n < w)
            push(8 + n, 8 + r, 5'h07, b4 ? {4'h0, j ? d[3:0] : d[7:4]} :
                 d[7:0], b4 ? 8'h0f : 8'hff);
          n++;
        end
      end
    end
    rect({3'b010, swp, 2'b00, bus, 9'h1f3}, w, 2);
    foreach (q[i])
      wr(`A_PIXEL, q[i]);
    poll(`ST_BUSY, "image write");
  endtask
  // --------------------
  // main sequence
  // --------------------
  initial begin
    logic [15:0] s;
    logic [7:0] c1, c2;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    io_addr_i = 16'h0000;
    io_wdata_i = 16'h0000;
    bpp4_i = 1'b0;
    rst_b_i = 1'b0;
    n_errors = 0;
    num_checks = 0;
    for (int i = 0; i < 256; i++)
      exp_mem[i] = i[7:0] ^ 8'h5a;
    void'($urandom(32'h1c58886c));
    repeat (6) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    rd(`A_CMD, s);
    chk_reg("status", 16'h0000, s);
    rd(`A_FG_MIX, s);
    chk_reg("unmapped", 16'h0000, s);
    c1 = 8'($urandom());
    c2 = 8'($urandom());
    poll(5, "");
    wr(`A_FG_MIX, 16'h0027);
    wr(`A_FG_COLOR, {8'h00, c1});
    wr(`A_MULTI, 16'ha000);
    for (int d = 0; d < 4; d++) begin
      for (int r = 0; r < 2; r++)
        for (int c = 0; c < 3; c++)
          push(8 + (d[0] ? c : -c), 8 + (d[1] ? r : -r), 5'h07, c1,
               8'hff);
      rect({8'h40, d[1], 1'b1, d[0], 5'h13}, 3, 2);
      poll(`ST_BUSY, "rectangle corner");
    end
    rect(16'h40e3, 2, 2);
    poll(`ST_BUSY, "move only");
    poll(3, "");
    wr(`A_BG_MIX, 16'h0005);
    wr(`A_BG_COLOR, {8'h00, c2});
    wr(`A_MULTI, 16'ha080);
    for (int m = 0; m < 3; m++)
      line(m, c1, c2);
    poll(6, "");
    wr(`A_FG_MIX, 16'h0047);
    wr(`A_MULTI, 16'ha000);
    image(1'b1, 1'b1, 1'b0, 3);
    image(1'b1, 1'b0, 1'b0, 3);
    image(1'b0, 1'b0, 1'b0, 3);
    image(1'b1, 1'b0, 1'b1, 5);
    image(1'b0, 1'b0, 1'b1, 5);
    conclude();
  end
endmodule // tb_top
`default_nettype wire

/* verification/vmem_model.sv */
// video memory model with random ack delay
`timescale 1ns/1ps
`default_nettype none
module vmem_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [11:0] x_i,
  input wire logic [11:0] y_i,
  input wire logic [7:0] wdata_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:255];
  logic [7:0] last_q;
  int cnt;
  int idx;
  // --------------------
  // bitmap start pattern
  // --------------------
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0] ^ 8'h5a;
    ack_o = 1'b0;
    rdata_o = 8'h00;
    last_q = 8'h00;
    cnt = 0;
  end
  // ack after 1..5 cycles; read line inverts when not answering
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~last_q;
    if (req_i && !ack_o) begin
      if (cnt == 0) begin
        idx = {y_i[3:0], x_i[3:0]};
        ack_o <= 1'b1;
        cnt <= $urandom_range(4);
        if (we_i)
          mem[idx] <= wdata_i;
        else begin
          rdata_o <= mem[idx];
          last_q <= mem[idx];
        end
      end else
        cnt <= cnt - 1;
    end
  end
endmodule // vmem_model
`default_nettype wire
